// file: rtl/otfs_top.sv
// output terminal function selector for the digital outputs
//
// Function
// - underload pre-alarm code drives the output from the timed underload alarm
// - sequencer stage code drives the output when the current stage finishes
// - sequencer cycle code drives the output when a whole cycle finishes
// - serial, fieldbus and ethernet virtual codes copy the written bit
// - industrial ethernet virtual code drives on for one, off for zero
// - bus voltage code is on while bus stays above undervoltage
// - index code asserts on index pulse and drops 10 ms later
// - pulse superposition code follows the superposition input function
// - safe torque off code asserts when that fault has occurred
// - positioning code is on once positioning has completed
// - spindle zeroing code is on once zeroing has completed
// - scale division code is on once scale division has completed
// - speed limit code is on while output frequency is limited
// - switchover code is on once speed/position switchover completed
// - codes 41 to 47 pass logic bits only when logic enable set
// - code zero leaves the output inactive
// - one code may drive several outputs independently
`timescale 1ns/10ps
`include "otfs_cfg.svh"
module otfs_top
    import otfs_pkg::*;
#(
    parameter int unsigned INDEX_HOLD_CYC = `OTFS_INDEX_HOLD_CYC
) (
    input  wire logic         I_SYS_CLK,
    input  wire logic         I_RESET_N,
    input  wire logic         I_CE,
    input  wire otfs_status_s I_STATUS,
    input  wire otfs_logic_t  I_LOGIC_BITS,
    input  wire logic         I_PROG_LOGIC_EN,
    input  wire logic         I_CODE_WE,
    input  wire logic [1:0]   I_CODE_SEL,
    input  wire otfs_code_t   I_CODE,
    output logic [3:0]        O_TERMINAL,
    output otfs_code_t        O_CODE_Y,
    output otfs_code_t        O_CODE_PULSE,
    output otfs_code_t        O_CODE_RLY1,
    output otfs_code_t        O_CODE_RLY2
);
    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers, three stages, change taken when last two agree
    localparam int NIN = 24;
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] sync1;
    logic [NIN-1:0] sync2;
    logic [NIN-1:0] sync3;
    logic [NIN-1:0] clean;
    logic [NIN-1:0] next_clean;

    assign raw_in = {I_PROG_LOGIC_EN, I_LOGIC_BITS, I_STATUS};

    genvar g;
    generate
        for (g = 0; g < NIN; g++) begin : g_filt
            always_comb begin
                next_clean[g] = (sync2[g] == sync3[g]) ? sync3[g] : clean[g];
            end
        end
    endgenerate

    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            clean <= '0;
        end else if (I_CE) begin
            sync1 <= raw_in;
            sync2 <= sync1;
            sync3 <= sync2;
            clean <= next_clean;
        end
    end

    otfs_status_s st;
    otfs_logic_t  lbits;
    logic         lenable;
    assign st      = otfs_status_s'(clean[15:0]);
    assign lbits   = clean[22:16];
    assign lenable = clean[23];

    ////////////////////////////////////////////////////////////////////////
    // index pulse stretch
    logic index_hold;

    otfs_index_stretch #(
        .HOLD_CYC (INDEX_HOLD_CYC)
    ) u_index (
        .i_clk       (I_SYS_CLK),
        .i_rst_n     (rst_n),
        .i_ce        (I_CE),
        .i_index     (st.index_pulse),
        .o_stretched (index_hold)
    );

    ////////////////////////////////////////////////////////////////////////
    // function codes per output
    otfs_code_t codes      [4];
    otfs_code_t next_codes [4];

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            next_codes[i] = codes[i];
        end
        if (I_CODE_WE) begin
            next_codes[I_CODE_SEL] = I_CODE;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            codes[0] <= `OTFS_RST_CODE_Y;
            codes[1] <= `OTFS_RST_CODE_PULSE;
            codes[2] <= `OTFS_RST_CODE_RLY1;
            codes[3] <= `OTFS_RST_CODE_RLY2;
        end else if (I_CE) begin
            codes <= next_codes;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // selection
    function automatic logic sel_source(input otfs_code_t c, input otfs_status_s s,
                                        input logic idx, input otfs_logic_t lb, input logic len);
        logic r;
        r = 1'b0;
        case (c)
            `OTFS_CODE_INVALID:   r = 1'b0;
            `OTFS_CODE_UNDERLOAD: r = s.underload_alarm;
            `OTFS_CODE_SEQ_STAGE: r = s.seq_stage_done;
            `OTFS_CODE_SEQ_CYCLE: r = s.seq_cycle_done;
            `OTFS_CODE_VT_SERIAL: r = s.vt_serial;
            `OTFS_CODE_VT_FBUS:   r = s.vt_fieldbus;
            `OTFS_CODE_VT_ETH:    r = s.vt_ethernet;
            `OTFS_CODE_BUS_OK:    r = s.bus_voltage_ok;
            `OTFS_CODE_INDEX:     r = idx;
            `OTFS_CODE_PULSE_SUP: r = s.pulse_superposition;
            `OTFS_CODE_STO:       r = s.safe_torque_off_fault;
            `OTFS_CODE_POS_DONE:  r = s.positioning_done;
            `OTFS_CODE_ZERO_DONE: r = s.spindle_zero_done;
            `OTFS_CODE_DIV_DONE:  r = s.spindle_div_done;
            `OTFS_CODE_SPD_LIM:   r = s.speed_limited;
            `OTFS_CODE_VT_IETH:   r = s.vt_industrial_eth;
            `OTFS_CODE_SWITCH:    r = s.mode_switch_done;
            default: begin
                if (c >= `OTFS_CODE_LOGIC_LO && c <= `OTFS_CODE_LOGIC_HI) begin
                    r = len & lb[3'(c - `OTFS_CODE_LOGIC_LO)];
                end else begin
                    r = 1'b0;
                end
            end
        endcase
        return r;
    endfunction

    logic [3:0] term;
    logic [3:0] next_term;

    generate
        for (g = 0; g < 4; g++) begin : g_sel
            always_comb begin
                next_term[g] = sel_source(codes[g], st, index_hold, lbits, lenable);
            end
        end
    endgenerate

    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            term <= 4'h0;
        end else if (I_CE) begin
            term <= next_term;
        end
    end

    assign O_TERMINAL   = term;
    assign O_CODE_Y     = codes[0];
    assign O_CODE_PULSE = codes[1];
    assign O_CODE_RLY1  = codes[2];
    assign O_CODE_RLY2  = codes[3];
endmodule

// file: rtl/otfs_cfg.svh
// constants for the output terminal function selector
`ifndef OTFS_CFG_SVH
`define OTFS_CFG_SVH
`define OTFS_NUM_OUT        4
`define OTFS_CODE_W         6
`define OTFS_CODE_INVALID   6'h00
`define OTFS_CODE_UNDERLOAD 6'h0F
`define OTFS_CODE_SEQ_STAGE 6'h10
`define OTFS_CODE_SEQ_CYCLE 6'h11
`define OTFS_CODE_VT_SERIAL 6'h17
`define OTFS_CODE_VT_FBUS   6'h18
`define OTFS_CODE_VT_ETH    6'h19
`define OTFS_CODE_BUS_OK    6'h1A
`define OTFS_CODE_INDEX     6'h1B
`define OTFS_CODE_PULSE_SUP 6'h1C
`define OTFS_CODE_STO       6'h1D
`define OTFS_CODE_POS_DONE  6'h1E
`define OTFS_CODE_ZERO_DONE 6'h1F
`define OTFS_CODE_DIV_DONE  6'h20
`define OTFS_CODE_SPD_LIM   6'h21
`define OTFS_CODE_VT_IETH   6'h22
`define OTFS_CODE_SWITCH    6'h24
`define OTFS_CODE_LOGIC_LO  6'h29
`define OTFS_CODE_LOGIC_HI  6'h2F
`define OTFS_RST_CODE_Y     6'h00
`define OTFS_RST_CODE_PULSE 6'h00
`define OTFS_RST_CODE_RLY1  6'h01
`define OTFS_RST_CODE_RLY2  6'h05
`define OTFS_CLK_MHZ        100
`define OTFS_INDEX_HOLD_MS  10
`define OTFS_INDEX_HOLD_CYC (`OTFS_INDEX_HOLD_MS * 1000 * `OTFS_CLK_MHZ)
`endif

// file: rtl/otfs_pkg.sv
// types for the output terminal function selector
package otfs_pkg;
    typedef logic [5:0] otfs_code_t;
    typedef struct packed {
        logic       underload_alarm;
        logic       seq_stage_done;
        logic       seq_cycle_done;
        logic       vt_serial;
        logic       vt_fieldbus;
        logic       vt_ethernet;
        logic       vt_industrial_eth;
        logic       bus_voltage_ok;
        logic       index_pulse;
        logic       pulse_superposition;
        logic       safe_torque_off_fault;
        logic       positioning_done;
        logic       spindle_zero_done;
        logic       spindle_div_done;
        logic       speed_limited;
        logic       mode_switch_done;
    } otfs_status_s;
    // order: transistor one, two, pulse terminal, relay one to four
    typedef logic [6:0] otfs_logic_t;
endpackage

// file: rtl/otfs_index_stretch.sv
// stretches the encoder index pulse to a fixed hold time
`timescale 1ns/10ps
`include "otfs_cfg.svh"
module otfs_index_stretch
    import otfs_pkg::*;
#(
    parameter int unsigned HOLD_CYC = `OTFS_INDEX_HOLD_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_ce,
    input  wire logic i_index,
    output logic      o_stretched
);
    logic [20:0] count;
    logic [20:0] next_count;
    logic        index_d;
    logic        next_index_d;
    logic        active;
    logic        next_active;

    always_comb begin
        next_index_d = i_index;
        next_count   = count;
        next_active  = active;
        if (i_index && !index_d) begin
            next_active = 1'b1;
            next_count  = 21'(HOLD_CYC - 1);
        end else if (active) begin
            if (count == 21'h000000) begin
                next_active = 1'b0;
            end else begin
                next_count = count - 21'h000001;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count   <= 21'h000000;
            index_d <= 1'b0;
            active  <= 1'b0;
        end else if (i_ce) begin
            count   <= next_count;
            index_d <= next_index_d;
            active  <= next_active;
        end
    end

    assign o_stretched = active;
endmodule

// file: testbench/otfs_top_chk.sv
// assertions on the selector top ports
`timescale 1ns/10ps
`include "otfs_cfg.svh"
module otfs_top_chk
    import otfs_pkg::*;
#(
    parameter int unsigned INDEX_HOLD_CYC = `OTFS_INDEX_HOLD_CYC
) (
    input wire logic         I_SYS_CLK,
    input wire logic         I_RESET_N,
    input wire logic         I_CE,
    input wire otfs_status_s I_STATUS,
    input wire otfs_logic_t  I_LOGIC_BITS,
    input wire logic         I_PROG_LOGIC_EN,
    input wire logic         I_CODE_WE,
    input wire logic [1:0]   I_CODE_SEL,
    input wire otfs_code_t   I_CODE,
    input wire logic [3:0]   O_TERMINAL,
    input wire otfs_code_t   O_CODE_Y,
    input wire otfs_code_t   O_CODE_PULSE,
    input wire otfs_code_t   O_CODE_RLY1,
    input wire otfs_code_t   O_CODE_RLY2
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RESET_N);
    code_take_a: assert property (I_CODE_WE && I_CE && I_CODE_SEL == 2'h2
        |=> O_CODE_RLY1 == $past(I_CODE))
        else $error("code write lost");
    code_hold_a: assert property (!(I_CODE_WE && I_CE)
        |=> $stable({O_CODE_Y, O_CODE_PULSE, O_CODE_RLY1, O_CODE_RLY2}))
        else $error("code moved without write");
    ce_freeze_a: assert property (!I_CE |=> $stable(O_TERMINAL))
        else $error("terminal moved while frozen");
    idle_code_a: assert property ($past(O_CODE_Y) == `OTFS_CODE_INVALID |-> !O_TERMINAL[0])
        else $error("invalid code drove output");
    reserved_code_a: assert property (
        $past(O_CODE_RLY2) inside {6'h23, [6'h25:6'h28], [6'h30:6'h3F]} |-> !O_TERMINAL[3])
        else $error("reserved code drove output");
    logic_off_a: assert property (
        (I_CE && !I_PROG_LOGIC_EN && O_CODE_PULSE inside {[6'h29:6'h2F]})[*6] |-> !O_TERMINAL[1])
        else $error("logic bit passed while disabled");
    bus_ok_a: assert property (
        (I_CE && O_CODE_Y == `OTFS_CODE_BUS_OK && I_STATUS.bus_voltage_ok)[*6] |-> O_TERMINAL[0])
        else $error("bus voltage output low");
    pos_lag_a: assert property (
        (I_CE && O_CODE_Y == `OTFS_CODE_POS_DONE)[*7] |-> O_TERMINAL[0] == $past(I_STATUS.positioning_done, 5))
        else $error("positioning output wrong");
    same_code_a: assert property ($past(O_CODE_Y) == $past(O_CODE_RLY2) |-> O_TERMINAL[0] == O_TERMINAL[3])
        else $error("shared code outputs differ");
endmodule
bind otfs_top otfs_top_chk #(.INDEX_HOLD_CYC(INDEX_HOLD_CYC)) u_chk (.*);

// file: testbench/otfs_field_model.sv
// field wiring: relay contacts lag their coil drive
`timescale 1ns/10ps
module otfs_field_model #(
    parameter int RELAY_CYC = 3
) (
    input  wire logic       i_clk,
    input  wire logic [3:0] i_drive,
    output logic      [3:0] o_contact
);
    logic [3:0] coil [RELAY_CYC];
    always_ff @(posedge i_clk) begin
        coil[0] <= i_drive;
        for (int i = 1; i < RELAY_CYC; i++) begin
            coil[i] <= coil[i-1];
        end
    end
    assign o_contact = {coil[RELAY_CYC-1][3:2], i_drive[1:0]};
endmodule

// file: testbench/otfs_top_tb.sv
// self-checking bench for the output terminal function selector
`timescale 1ns/10ps
`include "otfs_cfg.svh"
module otfs_top_tb;
    import otfs_pkg::*;
    logic         clk = 0, rst_n = 0, ce = 1, we = 0, len = 0;
    logic [1:0]   sel = '0;
    otfs_code_t   code = '0;
    otfs_status_s st = '0;
    otfs_logic_t  lb = '0;
    logic [3:0]   term, contact;
    otfs_code_t   cy, cp, c1, c2;
    int           errors = 0, comparisons = 0, cyc = 0;
    otfs_code_t   map [16] = '{6'h24, 6'h21, 6'h20, 6'h1F, 6'h1E, 6'h1D, 6'h1C, 6'h1B,
                               6'h1A, 6'h22, 6'h19, 6'h18, 6'h17, 6'h11, 6'h10, 6'h0F};
    otfs_code_t   rsv [6] = '{6'h00, 6'h23, 6'h25, 6'h28, 6'h30, 6'h3F};
    always #5 clk = ~clk;
    otfs_top #(.INDEX_HOLD_CYC(20)) dut (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_CE(ce), .I_STATUS(st),
        .I_LOGIC_BITS(lb), .I_PROG_LOGIC_EN(len), .I_CODE_WE(we), .I_CODE_SEL(sel), .I_CODE(code),
        .O_TERMINAL(term), .O_CODE_Y(cy), .O_CODE_PULSE(cp), .O_CODE_RLY1(c1), .O_CODE_RLY2(c2));
    otfs_field_model #(.RELAY_CYC(3)) field (.i_clk(clk), .i_drive(term), .o_contact(contact));
    ////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [1:0] s, input otfs_code_t c);
        sel = s;
        code = c;
        we = 1;
        tick(1);
        we = 0;
        tick(1);
    endtask
    task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            stop_test;
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        tick(6);
        rst_n = 1;
        tick(3);
        chk(cy, `OTFS_RST_CODE_Y);
        chk(cp, `OTFS_RST_CODE_PULSE);
        chk(c1, `OTFS_RST_CODE_RLY1);
        chk(c2, `OTFS_RST_CODE_RLY2);
        chk(term, 4'h0);
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            if (i == 7) continue;
            wr(2'(i), map[i]);
            st = otfs_status_s'(16'h1 << i);
            tick(8);
            chk(term[i % 4], 1'b1);
            st = '0;
            tick(8);
            chk(term[i % 4], 1'b0);
        end
        $display("status test done");
        st = '1;
        lb = '1;
        len = 1;
        for (int i = 0; i < 24; i++) begin
            wr(2'(i), rsv[i / 4]);
            tick(7);
            chk(term[i % 4], 1'b0);
        end
        $display("reserved test done");
        st = '0;
        for (int k = 0; k < 7; k++) begin
            wr(2'h1, 6'h29 + 6'(k));
            lb = 7'(1 << k);
            len = 1;
            tick(8);
            chk(term[1], 1'b1);
            lb = ~lb;
            tick(8);
            chk(term[1], 1'b0);
            lb = ~lb;
            len = 0;
            tick(8);
            chk(term[1], 1'b0);
        end
        $display("logic test done");
        wr(2'h2, `OTFS_CODE_INDEX);
        st.index_pulse = 1;
        tick(3);
        st.index_pulse = 0;
        tick(5);
        chk(term[2], 1'b1);
        tick(12);
        chk(term[2], 1'b1);
        tick(18);
        chk(term[2], 1'b0);
        $display("index test done");
        wr(2'h0, `OTFS_CODE_BUS_OK);
        wr(2'h3, `OTFS_CODE_BUS_OK);
        st.bus_voltage_ok = 1;
        tick(10);
        chk(term, 4'h9);
        chk(contact, 4'h9);
        $display("shared code test done");
        ce = 0;
        st.bus_voltage_ok = 0;
        wr(2'h0, 6'h00);
        tick(8);
        chk(term, 4'h9);
        chk(cy, `OTFS_CODE_BUS_OK);
        ce = 1;
        tick(8);
        chk(term, 4'h0);
        $display("freeze test done");
        stop_test;
    end
endmodule
